// ==== verilog/task_file_defines.svh ====
/*
 Register offsets, field positions and reset values of the task-file status/control bank.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef TASK_FILE_DEFINES_SVH
`define TASK_FILE_DEFINES_SVH
`define OFS_DEVICE_HEAD 12'h000
`define OFS_STATUS 12'h004
`define OFS_STATUS_SHADOW 12'h008
`define OFS_COMMAND 12'h00c
`define OFS_DEVICE_CONTROL 12'h010
`define OFS_DRIVE_ADDRESS 12'h014
`define OFS_CORE_EVENTS 12'h018
`define OFS_CONFIG 12'h01c
`define DH_LBA_BIT 6
`define DH_UNIT_BIT 4
`define DH_RESET 8'ha0
`define DC_SOFT_RESET_BIT_BIT 2
`define DC_IRQ_DISABLE_BIT_BIT 1
`define DC_RESET 8'h08
`define ST_BUSY 7
`define ST_READY 6
`define ST_WFAULT 5
`define ST_SEEK 4
`define ST_XFER 3
`define ST_FIXED 2
`define ST_INDEX 1
`define ST_FAULT 0
`define ST_RESET 8'h50
`endif

// ==== verilog/task_file_pkg.sv ====
/*
 Types shared by the task-file bank files.
 Assumes the defines header is included where offsets are needed.
*/
package task_file_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic read;
  } bus_req_s;
  typedef struct packed {
    logic set_busy;
    logic clr_busy;
    logic set_wfault;
    logic set_seek;
    logic set_xfer;
    logic clr_xfer;
    logic set_fixed;
    logic set_fault;
  } core_ev_s;
  typedef enum logic [1:0] {ADDR_IDLE, ADDR_DATA} phase_e;
endpackage

// ==== verilog/status_flag_cell.sv ====
/*
 One sticky status flag: hardware set beats clear in the same cycle.
 Assumes same-clock set and clear pulses.
*/
`timescale 1ns/10ps
module status_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= RESET_VAL;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ==== verilog/task_file_regs.sv ====
/*
 Task-file status/control register bank as an AHB-Lite slave: device/head, status,
 alternate status, command, device control and legacy drive address.
 Assumes a single AHB-Lite master with word transfers; the card core drives event pulses
 on hclk; interrupt source and drive-active inputs come from the same clock domain.
*/
`timescale 1ns/10ps
`include "task_file_defines.svh"
module task_file_regs
  import task_file_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Card core
  input wire core_ev_s core_ev,
  input wire logic unit_active,
  input wire logic irq_source,
  input wire logic io_mode_indexed,
  input wire logic level_irq_mode,
  output logic [7:0] command_q,
  output logic command_strobe_q,
  output logic lba_mode_q,
  output logic unit_select_q,
  output logic [3:0] head_bits_q,
  output logic soft_reset_q,
  output logic host_interrupt_request_q,
  output logic drive_addr_bit7_oe_q
);
  phase_e phase_q;
  bus_req_s req_q;
  logic [7:0] device_head_q;
  logic [7:0] device_control_q;
  logic [7:0] status_flags;
  logic [7:0] drive_address;
  logic [7:0] rd_byte;
  logic [7:0] cfg_q;
  logic irq_pending_q;
  logic wr_cmd;
  logic rd_status;
  logic task_reset;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flag_vec;

  // Address phase capture; zero wait states so hreadyout stays high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= ADDR_IDLE;
      req_q <= '0;
    end else if (hready) begin
      if (hsel && htrans[1]) begin
        phase_q <= ADDR_DATA;
        req_q.addr <= haddr;
        req_q.write <= hwrite;
        req_q.read <= !hwrite;
      end else begin
        phase_q <= ADDR_IDLE;
        req_q <= '0;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  logic data_wr;
  assign data_wr = (phase_q == ADDR_DATA) && req_q.write;
  assign wr_cmd = data_wr && (req_q.addr == `OFS_COMMAND);
  assign rd_status = (phase_q == ADDR_DATA) && req_q.read && (req_q.addr == `OFS_STATUS);
  assign task_reset = device_control_q[`DC_SOFT_RESET_BIT_BIT];

  // Device/head select; held at its reset value while soft reset stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_head_q <= `DH_RESET;
    end else if (task_reset) begin
      device_head_q <= `DH_RESET;
    end else if (data_wr && req_q.addr == `OFS_DEVICE_HEAD) begin
      device_head_q <= hwdata[7:0];
    end
  end

  // Device control lives outside the task file, so soft reset never clears itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_control_q <= `DC_RESET;
    end else if (data_wr && req_q.addr == `OFS_DEVICE_CONTROL) begin
      device_control_q <= {4'h0, 1'b1, hwdata[`DC_SOFT_RESET_BIT_BIT], hwdata[`DC_IRQ_DISABLE_BIT_BIT], 1'b0};
    end
  end

  // Scratch configuration word, software visible only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= 8'h00;
    end else if (data_wr && req_q.addr == `OFS_CONFIG) begin
      cfg_q <= hwdata[7:0];
    end
  end

  // Command register; ignored during soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command_q <= 8'h00;
      command_strobe_q <= 1'b0;
    end else begin
      command_strobe_q <= wr_cmd && !task_reset;
      if (wr_cmd && !task_reset) begin
        command_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lba_mode_q <= 1'b0;
      unit_select_q <= 1'b0;
      head_bits_q <= 4'h0;
      soft_reset_q <= 1'b0;
    end else begin
      lba_mode_q <= device_head_q[`DH_LBA_BIT];
      unit_select_q <= device_head_q[`DH_UNIT_BIT];
      head_bits_q <= device_head_q[3:0];
      soft_reset_q <= task_reset;
    end
  end

  // Per-flag set/clear; a new command clears transfer, fixed, write fault and fault, soft reset clears all
  always_comb begin
    set_vec = '0;
    clr_vec = {8{task_reset}};
    set_vec[`ST_BUSY] = core_ev.set_busy;
    clr_vec[`ST_BUSY] = core_ev.clr_busy || task_reset;
    set_vec[`ST_READY] = core_ev.clr_busy;
    clr_vec[`ST_READY] = core_ev.set_busy || task_reset;
    set_vec[`ST_WFAULT] = core_ev.set_wfault;
    clr_vec[`ST_WFAULT] = wr_cmd || task_reset;
    set_vec[`ST_SEEK] = core_ev.set_seek;
    set_vec[`ST_XFER] = core_ev.set_xfer;
    clr_vec[`ST_XFER] = wr_cmd || core_ev.clr_xfer || task_reset;
    set_vec[`ST_FIXED] = core_ev.set_fixed;
    clr_vec[`ST_FIXED] = wr_cmd || task_reset;
    clr_vec[`ST_INDEX] = 1'b1;
    set_vec[`ST_FAULT] = core_ev.set_fault;
    clr_vec[`ST_FAULT] = wr_cmd || task_reset;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      status_flag_cell #(
        .RESET_VAL(1'((`ST_RESET >> gi) & 8'h01))
      ) u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_i(set_vec[gi] && !task_reset && gi != `ST_INDEX),
        .clr_i(clr_vec[gi]),
        .flag_q(flag_vec[gi])
      );
    end
  endgenerate

  always_comb begin
    status_flags = flag_vec;
    status_flags[`ST_INDEX] = 1'b0;
  end

  // Drive address: bit 7 is not driven; read data shows zero there
  always_comb begin
    drive_address = 8'h00;
    drive_address[6] = 1'b0;
    drive_address[5:2] = ~device_head_q[3:0];
    drive_address[1] = !(unit_active && device_head_q[`DH_UNIT_BIT]);
    drive_address[0] = !(unit_active && !device_head_q[`DH_UNIT_BIT]);
  end

  // Write-only offsets read back the read-side register of the shared location.
  // Decoded from the address phase so the byte stands for the whole data phase.
  always_comb begin
    unique case (haddr)
      `OFS_DEVICE_HEAD: rd_byte = device_head_q;
      `OFS_STATUS, `OFS_COMMAND: rd_byte = status_flags;
      `OFS_STATUS_SHADOW, `OFS_DEVICE_CONTROL: rd_byte = status_flags;
      `OFS_DRIVE_ADDRESS: rd_byte = drive_address;
      `OFS_CORE_EVENTS: rd_byte = {6'h00, soft_reset_q, irq_pending_q};
      `OFS_CONFIG: rd_byte = cfg_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // Bit 7 enable is low always; it is only meaningful as an output enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_addr_bit7_oe_q <= 1'b0;
    end else begin
      drive_addr_bit7_oe_q <= 1'b0;
    end
  end

  // Pending interrupt: source set wins over status-read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending_q <= 1'b0;
    end else if (irq_source && !task_reset) begin
      irq_pending_q <= 1'b1;
    end else if (task_reset || (rd_status && io_mode_indexed && level_irq_mode)) begin
      irq_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_interrupt_request_q <= 1'b0;
    end else begin
      host_interrupt_request_q <= irq_pending_q && !device_control_q[`DC_IRQ_DISABLE_BIT_BIT];
    end
  end
endmodule

// ==== verif/task_file_checker.sv ====
/*
 Port assertions for the task-file bank.
 Assumes the bind below; one word transfer at a time.
*/
`timescale 1ns/10ps
`include "task_file_defines.svh"
module task_file_checker (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core side
  input wire logic irq_source,
  input wire logic io_mode_indexed,
  input wire logic level_irq_mode,
  input wire logic [7:0] command_q,
  input wire logic command_strobe_q,
  input wire logic soft_reset_q,
  input wire logic host_interrupt_request_q,
  input wire logic drive_addr_bit7_oe_q
);
  logic dp_q;
  logic dw_q;
  logic [11:0] da_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      dw_q <= 1'b0;
      da_q <= 12'h000;
    end else begin
      dp_q <= hsel && htrans[1] && hreadyout;
      dw_q <= hwrite;
      da_q <= haddr;
    end
  end
  wire rd_st = dp_q && !dw_q && da_q == `OFS_STATUS;
  wire rd_sh = dp_q && !dw_q && da_q == `OFS_STATUS_SHADOW;
  wire rd_da = dp_q && !dw_q && da_q == `OFS_DRIVE_ADDRESS;
  wire wr_cmd = dp_q && dw_q && da_q == `OFS_COMMAND;
  wire wr_dc = dp_q && dw_q && da_q == `OFS_DEVICE_CONTROL;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cmd_take_a: assert property (wr_cmd && !soft_reset_q |=>
    command_strobe_q && command_q == $past(hwdata[7:0])) else $error("command not taken");
  strobe_cause_a: assert property ($rose(command_strobe_q) |-> $past(wr_cmd))
    else $error("command strobe without write");
  soft_reset_bit_set_a: assert property (wr_dc |-> ##2 soft_reset_q == $past(hwdata[2], 2))
    else $error("soft reset bit not taken");
  soft_reset_bit_hold_a: assert property (soft_reset_q && !wr_dc && !$past(wr_dc) |=> soft_reset_q)
    else $error("soft reset dropped by itself");
  irq_clear_a: assert property (rd_st && io_mode_indexed && level_irq_mode && !irq_source
    && !$past(irq_source) |-> ##[1:2] !host_interrupt_request_q) else $error("irq kept");
  shadow_keep_a: assert property (rd_sh && host_interrupt_request_q |=>
    host_interrupt_request_q) else $error("shadow read dropped irq");
  idx_zero_a: assert property (rd_st || rd_sh |-> !hrdata[1])
    else $error("index bit not zero");
  da_top_a: assert property (rd_da |-> hrdata[7:6] == 2'b00 && !drive_addr_bit7_oe_q)
    else $error("drive address top bits wrong");
endmodule
bind task_file_regs task_file_checker u_task_file_checker (.*);

// ==== verif/core_model.sv ====
/*
 Card core model: busy for four cycles per command, then completion events.
 Assumes the bank's one-cycle command strobe; code 00 ends in error on purpose.
*/
`timescale 1ns/10ps
module core_model
  import task_file_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command in, events out
  input wire logic command_strobe_q,
  input wire logic [7:0] command_q,
  output core_ev_s core_ev,
  output logic irq_source
);
  logic [2:0] cnt_q;
  logic [7:0] cmd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 3'h0;
      cmd_q <= 8'h00;
      core_ev <= '0;
      irq_source <= 1'b0;
    end else begin
      core_ev <= '0;
      irq_source <= 1'b0;
      if (command_strobe_q) begin
        cmd_q <= command_q;
        cnt_q <= 3'h4;
        core_ev.set_busy <= 1'b1;
      end else if (cnt_q == 3'h1) begin
        cnt_q <= 3'h0;
        core_ev.clr_busy <= 1'b1;
        core_ev.set_seek <= 1'b1;
        core_ev.set_fault <= cmd_q == 8'h00;
        core_ev.set_xfer <= cmd_q != 8'h00;
        core_ev.set_wfault <= cmd_q == 8'h30;
        core_ev.set_fixed <= cmd_q == 8'h30;
        irq_source <= 1'b1;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule

// ==== verif/task_file_regs_tb.sv ====
/*
 Self-checking bench: AHB-Lite master, read scoreboard, core model.
 Assumes the bank answers with zero wait states.
*/
`timescale 1ns/10ps
`include "task_file_defines.svh"
module task_file_regs_tb;
  import task_file_pkg::*;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic unit_active = 1'b1;
  logic io_mode_indexed = 1'b0;
  logic level_irq_mode = 1'b0;
  core_ev_s core_ev;
  logic irq_source;
  logic [7:0] command_q;
  logic command_strobe_q;
  logic irq;
  logic mon_rd = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [7:0] cmds[3] = '{8'h20, 8'h00, 8'h30};
  logic [7:0] sts[3] = '{8'h58, 8'h51, 8'h7c};
  int num_errors = 0;
  int check_count = 0;
  task_file_regs u_task_file_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_ev(core_ev),
    .unit_active(unit_active), .irq_source(irq_source), .io_mode_indexed(io_mode_indexed),
    .level_irq_mode(level_irq_mode), .command_q(command_q), .command_strobe_q(command_strobe_q),
    .lba_mode_q(), .unit_select_q(), .head_bits_q(), .soft_reset_q(),
    .host_interrupt_request_q(irq), .drive_addr_bit7_oe_q());
  core_model u_core_model (.hclk(hclk), .hresetn(hresetn), .command_strobe_q(command_strobe_q),
    .command_q(command_q), .core_ev(core_ev), .irq_source(irq_source));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] wd);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    bus(a, 1'b0, 8'h00);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (mon_rd) begin
      chk("read data", hrdata[7:0], exp_q.pop_front());
    end
    mon_rd <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    forever #4 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    d = $urandom(32'hf6bc);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_DEVICE_HEAD, 8'ha0);
    rd(`OFS_STATUS, 8'h50);
    rd(`OFS_DRIVE_ADDRESS, 8'h3e);
    rd(12'h100, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom) | 8'ha0;
      unit_active <= d[6];
      bus(`OFS_DEVICE_HEAD, 1'b1, d);
      rd(`OFS_DEVICE_HEAD, d);
      rd(`OFS_DRIVE_ADDRESS, {2'b00, ~d[3:0], ~(d[6] & d[4]), ~(d[6] & ~d[4])});
    end
    $display("device head done");
    io_mode_indexed <= 1'b1;
    level_irq_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(`OFS_COMMAND, 1'b1, cmds[i]);
      repeat (12) @(posedge hclk);
      chk("irq raised", {7'h0, irq}, 8'h01);
      bus(`OFS_STATUS, 1'b1, 8'hff);
      rd(`OFS_STATUS_SHADOW, sts[i]);
      rd(`OFS_STATUS, sts[i]);
    end
    $display("commands done");
    bus(`OFS_DEVICE_CONTROL, 1'b1, 8'h0a);
    bus(`OFS_COMMAND, 1'b1, 8'h20);
    repeat (12) @(posedge hclk);
    chk("irq masked", {7'h0, irq}, 8'h00);
    // Upper control bits are don't-care, so set them while entering soft reset
    bus(`OFS_DEVICE_CONTROL, 1'b1, 8'hf4);
    // Task-file reset lands one edge after the control write
    @(posedge hclk);
    rd(`OFS_DEVICE_HEAD, 8'ha0);
    bus(`OFS_COMMAND, 1'b1, 8'h20);
    repeat (12) @(posedge hclk);
    rd(`OFS_STATUS, 8'h00);
    bus(`OFS_DEVICE_CONTROL, 1'b1, 8'h08);
    @(posedge hclk);
    $display("soft reset done");
    stop_test();
  end
endmodule
